// ==== rtl/srpm_ctrl.sv ====
`timescale 1ns/10ps
`include "srpm_params.svh"
// Function
// - Row boundary breaks page: precharge, activate, reissue
// - Boundary break adds one cycle per delay
// - Periodic auto-refresh from reloaded down-timer
// - Refresh due while pending raises error
// - Status read acknowledges refresh error
// - SDRAM access waits during refresh
// - Enter low power when idle, after timeout
// - Select 1: self-refresh, clock-enable low
// - Access during self-refresh exits it first
// - Self-refresh lasts at least active-to-precharge delay
// - Select 2: power-down between accesses
// - Power-down still receives controller refreshes
// - Select 3: deep power-down command issued
// - Command mode selects forced command
// - Mode applies on next access, any cycle
// - Timeout field: 0, 64, 128 cycles
// - No auto-refresh until count written
// - Select 0: no low-power commands
// - Wait self-refresh exit delay before activate
module srpm_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Bus master access, request held until ack
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic acc_seq,
  input wire logic [1:0] acc_bank,
  input wire logic [12:0] acc_row,
  input wire logic [10:0] acc_col,
  output logic acc_ack,
  output logic acc_wait,
  // SDRAM pins
  output logic mem_clock_enable_out,
  output logic mem_cs_n,
  output logic mem_ras_n,
  output logic mem_cas_n,
  output logic mem_we_n,
  output logic [1:0] mem_bank,
  output logic [12:0] mem_addr
);
  import srpm_pkg::*;

  srpm_if cfg ();
  srpm_core_t q, d;
  logic [3:0] trc, precharge_to_active_delay, activate_to_command_delay, active_to_precharge_delay, self_refresh_exit_delay;
  logic ref_due;
  logic hit;
  logic boundary;
  logic [7:0] lp_dly;
  logic lp_ok;

  // Register file behind APB
  srpm_regs u_regs (
    .clk(clk),
    .nrst(nrst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq(irq),
    .cfg(cfg)
  );

  // Wait count, widened by one on a boundary break
  function automatic logic [7:0] wait_cnt(input logic [3:0] t, input logic extra);
    wait_cnt = {4'h0, t} + {7'h0, extra};
  endfunction

  // Idle cycles before low-power entry
  function automatic logic [7:0] lp_delay(input logic [1:0] tmo);
    case (tmo)
      2'h1: lp_delay = `SRPM_LP_DLY_64;
      2'h2: lp_delay = `SRPM_LP_DLY_128;
      default: lp_delay = 8'h00;
    endcase
  endfunction

  assign trc = cfg.timing[`SRPM_POS_TRC +: 4];
  assign precharge_to_active_delay = cfg.timing[`SRPM_POS_TRP +: 4];
  assign activate_to_command_delay = cfg.timing[`SRPM_POS_ACTIVATE_TO_COMMAND_DELAY +: 4];
  assign active_to_precharge_delay = cfg.timing[`SRPM_POS_ACTIVE_TO_PRECHARGE_DELAY +: 4];
  assign self_refresh_exit_delay = cfg.timing[`SRPM_POS_SELF_REFRESH_EXIT_DELAY +: 4];

  // Deep power-down has no timeout; the delay only holds off the others
  assign lp_dly = (cfg.lp_sel == `SRPM_LP_DEEP) ? 8'h00 : lp_delay(cfg.lp_timeout);
  assign lp_ok = cfg.lp_sel != `SRPM_LP_OFF;

  // Crossing into the next column of a new row counts as a boundary
  assign boundary = acc_seq && (acc_col == 11'h000);
  assign hit = q.vld[acc_bank] && (q.rows[acc_bank] == acc_row) && !boundary;
  assign ref_due = cfg.count_written && !cfg.tr_wr && (q.timer == 12'h000);

  // Handshake: master stalls until its access is acknowledged
  assign acc_ack = q.ack;
  assign acc_wait = acc_req && !q.ack;

  assign mem_clock_enable_out = q.cke;
  assign {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = q.cmd;
  assign mem_bank = q.bank;
  assign mem_addr = q.addr;
  assign cfg.ref_err_set = q.err_set;

  // Next state
  always_comb begin
    d = q;
    d.cmd = `SRPM_CMD_NOP;
    d.ack = 1'b0;
    d.err_set = 1'b0;
    if (d.cnt != 8'h00) begin
      d.cnt = q.cnt - 8'h01;
    end

    // Refresh timer; self-refresh and deep power-down need none
    if (!cfg.count_written) begin
      d.timer = q.timer;
    end else if (cfg.tr_wr || ref_due) begin
      // Reload one short: the zero state is a cycle too, so N gives N cycles
      d.timer = cfg.ref_count - 12'h001;
    end else begin
      d.timer = q.timer - 12'h001;
    end
    if (ref_due && q.st != SRPM_SR && q.st != SRPM_DPD) begin
      d.ref_pend = 1'b1;
      d.err_set = q.ref_pend;
    end

    case (q.st)
      SRPM_IDLE: begin
        if (q.ack) begin
          d.idle = 8'h00;
        end else if (q.ref_pend) begin
          // Banks must be closed before auto-refresh
          d.cmd = `SRPM_CMD_PRE;
          d.addr = 13'h0;
          d.addr[`SRPM_A10] = 1'b1;
          d.vld = 4'h0;
          d.cnt = {4'h0, precharge_to_active_delay};
          d.nxt = SRPM_REF_W;
          d.st = SRPM_PALL_W;
        end else if (acc_req && cfg.mode != `SRPM_MODE_NORMAL) begin
          // Forced command regardless of read or write
          d.ack = 1'b1;
          d.idle = 8'h00;
          d.bank = acc_bank;
          d.addr = acc_row;
          case (cfg.mode)
            `SRPM_MODE_NOP: d.cmd = `SRPM_CMD_NOP;
            `SRPM_MODE_PALL: begin
              d.cmd = `SRPM_CMD_PRE;
              d.addr[`SRPM_A10] = 1'b1;
              d.vld = 4'h0;
            end
            `SRPM_MODE_LMR: d.cmd = `SRPM_CMD_LMR;
            `SRPM_MODE_REF: d.cmd = `SRPM_CMD_REF;
            `SRPM_MODE_EMR: d.cmd = `SRPM_CMD_LMR;
            `SRPM_MODE_DPD: begin
              d.cmd = `SRPM_CMD_DPD;
              d.cke = 1'b0;
              d.vld = 4'h0;
              d.st = SRPM_DPD;
            end
            default: d.cmd = `SRPM_CMD_NOP;
          endcase
        end else if (acc_req) begin
          d.idle = 8'h00;
          d.bank = acc_bank;
          if (hit) begin
            d.cmd = acc_write ? `SRPM_CMD_WR : `SRPM_CMD_RD;
            d.addr = {2'h0, acc_col};
            d.ack = 1'b1;
          end else if (q.vld[acc_bank]) begin
            // Row change or boundary: close the open row first
            d.cmd = `SRPM_CMD_PRE;
            d.addr = 13'h0;
            d.brk = boundary;
            d.cnt = wait_cnt(precharge_to_active_delay, boundary);
            d.st = SRPM_PRE_W;
          end else begin
            d.cmd = `SRPM_CMD_ACT;
            d.addr = acc_row;
            d.vld[acc_bank] = 1'b1;
            d.rows[acc_bank] = acc_row;
            d.brk = 1'b0;
            d.cnt = {4'h0, activate_to_command_delay};
            d.st = SRPM_ACT_W;
          end
        end else if (lp_ok) begin
          // Count idle cycles since the last transfer
          if (q.idle < lp_dly) begin
            d.idle = q.idle + 8'h01;
          end else begin
            d.cmd = `SRPM_CMD_PRE;
            d.addr = 13'h0;
            d.addr[`SRPM_A10] = 1'b1;
            d.vld = 4'h0;
            d.cnt = {4'h0, precharge_to_active_delay};
            case (cfg.lp_sel)
              `SRPM_LP_SELF: d.nxt = SRPM_SR;
              `SRPM_LP_PDOWN: d.nxt = SRPM_PD;
              default: d.nxt = SRPM_DPD;
            endcase
            d.st = SRPM_PALL_W;
          end
        end else begin
          d.idle = 8'h00;
        end
      end
      SRPM_PALL_W: begin
        if (q.cnt == 8'h00) begin
          case (q.nxt)
            SRPM_REF_W: begin
              d.cmd = `SRPM_CMD_REF;
              d.ref_pend = d.err_set; // a due in this cycle stays pending
              d.cnt = {4'h0, trc};
              d.st = SRPM_REF_W;
            end
            SRPM_SR: begin
              d.cmd = `SRPM_CMD_REF;
              d.cke = 1'b0;
              d.ref_pend = 1'b0;
              d.cnt = {4'h0, active_to_precharge_delay};
              d.st = SRPM_SR;
            end
            SRPM_PD: begin
              d.cke = 1'b0;
              d.st = SRPM_PD;
            end
            default: begin
              d.cmd = `SRPM_CMD_DPD;
              d.cke = 1'b0;
              d.st = SRPM_DPD;
            end
          endcase
        end
      end
      SRPM_PRE_W: begin
        if (q.cnt == 8'h00) begin
          d.cmd = `SRPM_CMD_ACT;
          d.addr = acc_row;
          d.vld[acc_bank] = 1'b1;
          d.rows[acc_bank] = acc_row;
          d.cnt = wait_cnt(activate_to_command_delay, q.brk);
          d.st = SRPM_ACT_W;
        end
      end
      SRPM_ACT_W: begin
        if (q.cnt == 8'h00) begin
          // Reissue the pending read or write on the new row
          d.cmd = acc_write ? `SRPM_CMD_WR : `SRPM_CMD_RD;
          d.addr = {2'h0, acc_col};
          d.ack = 1'b1;
          d.brk = 1'b0;
          d.st = SRPM_IDLE;
        end
      end
      SRPM_REF_W: begin
        // Accesses keep waiting until the refresh recovery ends
        if (q.cnt == 8'h00) begin
          d.st = SRPM_IDLE;
        end
      end
      SRPM_SR: begin
        // Pins other than clock enable are don't care here
        d.cmd = `SRPM_CMD_DESEL;
        d.ref_pend = 1'b0;
        if (q.cnt == 8'h00 && (acc_req || cfg.lp_sel != `SRPM_LP_SELF)) begin
          d.cmd = `SRPM_CMD_NOP;
          d.cke = 1'b1;
          d.cnt = {4'h0, self_refresh_exit_delay};
          d.st = SRPM_SR_EXIT;
        end
      end
      SRPM_SR_EXIT: begin
        if (q.cnt == 8'h00) begin
          d.idle = 8'h00;
          d.st = SRPM_IDLE;
        end
      end
      SRPM_PD: begin
        d.cmd = `SRPM_CMD_DESEL;
        // Wake for an access or a refresh that falls due
        if (acc_req || q.ref_pend || cfg.lp_sel != `SRPM_LP_PDOWN) begin
          d.cmd = `SRPM_CMD_NOP;
          d.cke = 1'b1;
          d.idle = 8'h00;
          d.st = SRPM_IDLE;
        end
      end
      SRPM_DPD: begin
        d.cmd = `SRPM_CMD_DESEL;
        d.ref_pend = 1'b0;
        // Leaves only when low power is no longer deep and software accesses
        if (acc_req && cfg.lp_sel != `SRPM_LP_DEEP) begin
          d.cmd = `SRPM_CMD_NOP;
          d.cke = 1'b1;
          d.idle = 8'h00;
          d.st = SRPM_IDLE;
        end
      end
      default: d.st = SRPM_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '{st: SRPM_IDLE, nxt: SRPM_IDLE, cnt: 8'h00, idle: 8'h00,
             timer: 12'h000, ref_pend: 1'b0, err_set: 1'b0, vld: 4'h0,
             rows: '0, brk: 1'b0, cke: 1'b1, cmd: `SRPM_CMD_NOP,
             bank: 2'h0, addr: 13'h0000, ack: 1'b0};
    end else begin
      q <= d;
    end
  end
endmodule

// ==== pkg/srpm_params.svh ====
`ifndef SRPM_PARAMS_SVH
`define SRPM_PARAMS_SVH

// Register byte offsets
`define SRPM_OFS_MODE 8'h00
`define SRPM_OFS_REFRESH 8'h04
`define SRPM_OFS_TIMING 8'h08
`define SRPM_OFS_LOWPWR 8'h10
`define SRPM_OFS_IRQ_EN 8'h14
`define SRPM_OFS_IRQ_DIS 8'h18
`define SRPM_OFS_IRQ_MASK 8'h1c
`define SRPM_OFS_IRQ_STAT 8'h20
`define SRPM_OFS_MEM_TYPE 8'h24

// Reset values
`define SRPM_RST_MODE 3'h0
`define SRPM_RST_REFRESH 12'h000
`define SRPM_RST_TIMING 32'h852372c0
`define SRPM_RST_LOWPWR 14'h0000

// Writable bit masks
`define SRPM_MSK_LOWPWR 14'h3f73

// Timing field positions in the timing register
`define SRPM_POS_TRC 12
`define SRPM_POS_TRP 16
`define SRPM_POS_ACTIVATE_TO_COMMAND_DELAY 20
`define SRPM_POS_ACTIVE_TO_PRECHARGE_DELAY 24
`define SRPM_POS_SELF_REFRESH_EXIT_DELAY 28

// Low-power register field positions
`define SRPM_POS_LPSEL 0
`define SRPM_POS_TMO 12

// Low-power entry delays in cycles
`define SRPM_LP_DLY_64 8'h40
`define SRPM_LP_DLY_128 8'h80

// Command mode codes
`define SRPM_MODE_NORMAL 3'h0
`define SRPM_MODE_NOP 3'h1
`define SRPM_MODE_PALL 3'h2
`define SRPM_MODE_LMR 3'h3
`define SRPM_MODE_REF 3'h4
`define SRPM_MODE_EMR 3'h5
`define SRPM_MODE_DPD 3'h6

// Low-power select codes
`define SRPM_LP_OFF 2'h0
`define SRPM_LP_SELF 2'h1
`define SRPM_LP_PDOWN 2'h2
`define SRPM_LP_DEEP 2'h3

// SDRAM command pins {cs_n, ras_n, cas_n, we_n}
`define SRPM_CMD_DESEL 4'hf
`define SRPM_CMD_NOP 4'h7
`define SRPM_CMD_ACT 4'h3
`define SRPM_CMD_RD 4'h5
`define SRPM_CMD_WR 4'h4
`define SRPM_CMD_PRE 4'h2
`define SRPM_CMD_REF 4'h1
`define SRPM_CMD_LMR 4'h0
`define SRPM_CMD_DPD 4'h6

// Address bit that selects all banks on precharge
`define SRPM_A10 10

`endif

// ==== pkg/srpm_pkg.sv ====
package srpm_pkg;

  typedef enum logic [3:0] {
    SRPM_IDLE,
    SRPM_PALL_W,
    SRPM_PRE_W,
    SRPM_ACT_W,
    SRPM_REF_W,
    SRPM_SR,
    SRPM_SR_EXIT,
    SRPM_PD,
    SRPM_DPD
  } srpm_state_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [11:0] count;
    logic written;
    logic [31:0] timing;
    logic [13:0] lowpwr;
    logic mask;
    logic err;
    logic tr_wr;
    logic [31:0] rdata;
  } srpm_regs_t;

  typedef struct packed {
    srpm_state_t st;
    srpm_state_t nxt;
    logic [7:0] cnt;
    logic [7:0] idle;
    logic [11:0] timer;
    logic ref_pend;
    logic err_set;
    logic [3:0] vld;
    logic [3:0][12:0] rows;
    logic brk;
    logic cke;
    logic [3:0] cmd;
    logic [1:0] bank;
    logic [12:0] addr;
    logic ack;
  } srpm_core_t;

endpackage

// ==== pkg/srpm_if.sv ====
`timescale 1ns/10ps
interface srpm_if;
  logic [2:0] mode;
  logic [11:0] ref_count;
  logic count_written;
  logic tr_wr;
  logic [31:0] timing;
  logic [1:0] lp_sel;
  logic [1:0] lp_timeout;
  logic ref_err_set;

  modport regs (
    output mode, ref_count, count_written, tr_wr, timing, lp_sel, lp_timeout,
    input ref_err_set
  );
  modport core (
    input mode, ref_count, count_written, tr_wr, timing, lp_sel, lp_timeout,
    output ref_err_set
  );
endinterface

// ==== rtl/srpm_regs.sv ====
`timescale 1ns/10ps
`include "srpm_params.svh"
module srpm_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Core side
  srpm_if.regs cfg
);
  import srpm_pkg::*;

  srpm_regs_t q, d;
  logic acc;
  logic known;

  // Zero wait state: every access completes in its first access cycle
  assign pready = 1'b1;
  assign acc = psel && penable;
  assign pslverr = acc && !known;
  assign prdata = q.rdata;
  assign irq = q.err && q.mask;

  assign cfg.mode = q.mode;
  assign cfg.ref_count = q.count;
  assign cfg.count_written = q.written;
  assign cfg.tr_wr = q.tr_wr;
  assign cfg.timing = q.timing;
  assign cfg.lp_sel = q.lowpwr[`SRPM_POS_LPSEL +: 2];
  assign cfg.lp_timeout = q.lowpwr[`SRPM_POS_TMO +: 2];

  // Decode, write effects and read data capture
  always_comb begin
    d = q;
    d.tr_wr = 1'b0;
    known = 1'b1;
    case (paddr)
      `SRPM_OFS_MODE, `SRPM_OFS_REFRESH, `SRPM_OFS_TIMING, `SRPM_OFS_LOWPWR,
      `SRPM_OFS_IRQ_EN, `SRPM_OFS_IRQ_DIS, `SRPM_OFS_IRQ_MASK,
      `SRPM_OFS_IRQ_STAT, `SRPM_OFS_MEM_TYPE: known = 1'b1;
      default: known = 1'b0;
    endcase
    if (psel && !penable) begin
      // Read data is latched in setup so it stands during the access cycle
      case (paddr)
        `SRPM_OFS_MODE: d.rdata = {29'h0, q.mode};
        `SRPM_OFS_REFRESH: d.rdata = {20'h0, q.count};
        `SRPM_OFS_TIMING: d.rdata = q.timing;
        `SRPM_OFS_LOWPWR: d.rdata = {18'h0, q.lowpwr};
        `SRPM_OFS_IRQ_MASK: d.rdata = {31'h0, q.mask};
        `SRPM_OFS_IRQ_STAT: d.rdata = {31'h0, q.err || cfg.ref_err_set};
        default: d.rdata = 32'h0;
      endcase
    end
    if (acc && pwrite) begin
      case (paddr)
        `SRPM_OFS_MODE: d.mode = pwdata[2:0];
        `SRPM_OFS_REFRESH: begin
          d.count = pwdata[11:0];
          d.written = 1'b1;
          d.tr_wr = 1'b1;
        end
        `SRPM_OFS_TIMING: d.timing = pwdata;
        `SRPM_OFS_LOWPWR: d.lowpwr = pwdata[13:0] & `SRPM_MSK_LOWPWR;
        `SRPM_OFS_IRQ_EN: if (pwdata[0]) d.mask = 1'b1;
        `SRPM_OFS_IRQ_DIS: if (pwdata[0]) d.mask = 1'b0;
        default: ;
      endcase
    end
    // Status read clears; a new error in the same cycle survives
    if (acc && !pwrite && paddr == `SRPM_OFS_IRQ_STAT) begin
      d.err = 1'b0;
    end
    if (cfg.ref_err_set) begin
      d.err = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '{mode: `SRPM_RST_MODE, count: `SRPM_RST_REFRESH, written: 1'b0,
             timing: `SRPM_RST_TIMING, lowpwr: `SRPM_RST_LOWPWR, mask: 1'b0,
             err: 1'b0, tr_wr: 1'b0, rdata: 32'h0};
    end else begin
      q <= d;
    end
  end
endmodule

// ==== dv/srpm_ctrl_props.sv ====
`timescale 1ns/10ps
`include "srpm_params.svh"
module srpm_ctrl_props (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic irq,
  // Access port
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic acc_ack,
  input wire logic acc_wait,
  // SDRAM pins
  input wire logic mem_clock_enable_out,
  input wire logic mem_cs_n,
  input wire logic mem_ras_n,
  input wire logic mem_cas_n,
  input wire logic mem_we_n,
  input wire logic [12:0] mem_addr
);
  logic [2:0] mode_q;
  logic [1:0] lp_q;
  logic tr_q;
  logic mask_q;
  logic cke;
  logic [3:0] cmd;
  assign cke = mem_clock_enable_out;
  assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
  // Shadow of software settings; pready is tied high, so an access phase always ends
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= 3'h0;
      lp_q <= 2'h0;
      tr_q <= 1'b0;
      mask_q <= 1'b0;
    end else if (psel && penable && pwrite) begin
      if (paddr == `SRPM_OFS_MODE) mode_q <= pwdata[2:0];
      if (paddr == `SRPM_OFS_LOWPWR) lp_q <= pwdata[1:0];
      if (paddr == `SRPM_OFS_REFRESH) tr_q <= 1'b1;
      if (paddr == `SRPM_OFS_IRQ_EN && pwdata[0]) mask_q <= 1'b1;
      if (paddr == `SRPM_OFS_IRQ_DIS && pwdata[0]) mask_q <= 1'b0;
    end
  end
  // One clock domain throughout
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wait_level_a: assert property (acc_wait == (acc_req && !acc_ack))
    else $error("acc_wait not req and not ack");
  ref_stall_a: assert property (cmd == `SRPM_CMD_REF && mode_q != `SRPM_MODE_REF |=> !acc_ack [*7])
    else $error("access acked during refresh");
  ack_normal_a: assert property (acc_ack && mode_q == `SRPM_MODE_NORMAL
    |-> cmd == (acc_write ? `SRPM_CMD_WR : `SRPM_CMD_RD))
    else $error("normal access command wrong");
  ack_pall_a: assert property (acc_ack && mode_q == `SRPM_MODE_PALL
    |-> cmd == `SRPM_CMD_PRE && mem_addr[`SRPM_A10])
    else $error("forced precharge not all banks");
  early_ref_a: assert property (cmd == `SRPM_CMD_REF && cke |-> tr_q || mode_q == `SRPM_MODE_REF)
    else $error("refresh before count written");
  lp_off_a: assert property ($fell(cke) |-> lp_q != `SRPM_LP_OFF || mode_q == `SRPM_MODE_DPD)
    else $error("clock enable dropped with low power off");
  low_desel_a: assert property (!cke && !$past(cke) |-> mem_cs_n)
    else $error("command while clock enable low");
  sr_stay_a: assert property ($fell(cke) && lp_q == `SRPM_LP_SELF |-> !cke [*5])
    else $error("self-refresh left too early");
  sr_exit_a: assert property ($rose(cke) && lp_q == `SRPM_LP_SELF |-> cmd != `SRPM_CMD_ACT [*8])
    else $error("activate before exit delay");
  deep_cmd_a: assert property (cmd == `SRPM_CMD_DPD
    |-> mode_q == `SRPM_MODE_DPD || lp_q == `SRPM_LP_DEEP)
    else $error("deep power-down unasked");
  irq_mask_a: assert property (irq |-> mask_q)
    else $error("irq while masked");
  cover property (acc_ack && mode_q == `SRPM_MODE_REF);
  cover property ($fell(cke) && lp_q == `SRPM_LP_PDOWN);
  cover property ($rose(irq));
endmodule

bind srpm_ctrl srpm_ctrl_props u_srpm_ctrl_props (.clk, .nrst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .irq, .acc_req, .acc_write, .acc_ack, .acc_wait, .mem_clock_enable_out,
  .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_addr);

// ==== dv/srpm_mem_model.sv ====
`timescale 1ns/10ps
`include "srpm_params.svh"
module srpm_mem_model (
  // Clock
  input wire logic clk,
  // Command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  // Observed device state
  output int ref_cnt,
  output logic in_self,
  output logic in_deep
);
  logic cke_q = 1'b1;
  logic [3:0] cmd;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  initial begin
    ref_cnt = 0;
    in_self = 1'b0;
    in_deep = 1'b0;
  end
  // Commands count only with clock enable high the cycle before
  always @(posedge clk) begin
    cke_q <= cke;
    if (cke_q && cmd == `SRPM_CMD_REF && cke) ref_cnt <= ref_cnt + 1;
    if (cke_q && cmd == `SRPM_CMD_REF && !cke) in_self <= 1'b1;
    if (!cke_q && cke) in_self <= 1'b0;
    if (cke_q && cmd == `SRPM_CMD_DPD) in_deep <= 1'b1;
    if (cke_q && cmd == `SRPM_CMD_LMR) in_deep <= 1'b0;
  end
endmodule

// ==== dv/sdram_refresh_power_mode_ctrl_bench.sv ====
`timescale 1ns/10ps
`include "srpm_params.svh"
module sdram_refresh_power_mode_ctrl_bench;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic acc_req = 1'b0, acc_write = 1'b0, acc_seq = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] acc_bank = 2'h0, mem_bank;
  logic [12:0] acc_row = 13'h0, mem_addr;
  logic [10:0] acc_col = 11'h0;
  logic pready, pslverr, irq, acc_ack, acc_wait, cke, cs_n, ras_n, cas_n, we_n;
  logic last_err, in_self, in_deep, wt;
  logic [1:0] bank_at;
  logic [3:0] cmd, cmd_at;
  int errors = 0, num_checks = 0, lat, ref_cnt, cyc = 0, t_ref0 = 0, t_ref1 = 0, n;
  logic [2:0] fm [7] = '{3'h6, 3'h1, 3'h2, 3'h4, 3'h3, 3'h5, 3'h0};
  logic [3:0] fc [7] = '{4'h6, 4'h7, 4'h2, 4'h1, 4'h0, 4'h0, 4'h4};
  logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h1c, 8'h20, 8'h24};
  logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h852372c0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  always #2.5 clk = ~clk;
  srpm_ctrl u_srpm_ctrl (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .acc_req, .acc_write, .acc_seq, .acc_bank, .acc_row, .acc_col,
    .acc_ack, .acc_wait, .mem_clock_enable_out(cke), .mem_cs_n(cs_n), .mem_ras_n(ras_n),
    .mem_cas_n(cas_n), .mem_we_n(we_n), .mem_bank, .mem_addr);
  srpm_mem_model u_srpm_mem_model (.clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ref_cnt,
    .in_self, .in_deep);
  // Cycle count and stamps of the last two auto-refreshes
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cmd === `SRPM_CMD_REF && cke === 1'b1) begin
      t_ref0 <= t_ref1;
      t_ref1 <= cyc;
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // APB transfer; values are taken at the edge that samples pready, before it updates
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      errors++;
      end_sim();
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following setup never re-drives psel in this step
    @(posedge clk);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  // Access held until ack, then one idle cycle so the request is not re-driven at once
  task automatic acc(input logic w, input logic s, input logic [12:0] row, input logic [10:0] col);
    acc_req <= 1'b1;
    acc_write <= w;
    acc_seq <= s;
    acc_row <= row;
    acc_col <= col;
    lat = 0;
    wt = 1'b0;
    do begin
      @(posedge clk);
      lat++;
      if (lat == 7) wt = acc_wait;
    end while (acc_ack !== 1'b1 && lat < 400);
    if (lat >= 400) begin
      errors++;
      end_sim();
    end
    cmd_at = cmd;
    bank_at = mem_bank;
    acc_req <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // Reset values and the unmapped hole
    foreach (ra[i]) rdc("reset value", ra[i], rv[i]);
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped error", 32'h1, last_err);
    $display("test registers done");
    // Deep power-down by command, then a full new init sequence with every mode
    foreach (fm[i]) begin
      apb(1'b1, `SRPM_OFS_MODE, {29'h0, fm[i]});
      acc_bank <= (fm[i] == `SRPM_MODE_EMR) ? 2'h1 : 2'h0;
      acc(1'b1, 1'b0, 13'h0, 11'h0);
      chk("forced command", fc[i], cmd_at);
      chk("forced bank", {30'h0, acc_bank}, {30'h0, bank_at});
    end
    chk("closed bank latency", 32'd5, lat);
    acc(1'b0, 1'b0, 13'h0, 11'h4);
    chk("row hit latency", 32'd2, lat);
    acc(1'b1, 1'b1, 13'h0, 11'h0);
    chk("boundary latency", 32'd11, lat);
    chk("boundary command", `SRPM_CMD_WR, cmd_at);
    acc(1'b0, 1'b0, 13'h9, 11'h1);
    chk("row miss latency", 32'd9, lat);
    $display("test commands done");
    // Auto-refresh only after the count is written, then at the programmed period
    n = ref_cnt;
    repeat (300) @(posedge clk);
    chk("refresh before count", n, ref_cnt);
    apb(1'b1, `SRPM_OFS_REFRESH, 32'd100);
    repeat (260) @(posedge clk);
    chk("refresh interval", 32'd100, t_ref1 - t_ref0);
    n = 0;
    while (!(cmd === `SRPM_CMD_REF && cke === 1'b1) && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) begin
      errors++;
      end_sim();
    end
    acc(1'b0, 1'b0, 13'h9, 11'h2);
    chk("stall in refresh", 32'h1, lat > 7);
    chk("wait during refresh", 32'h1, {31'h0, wt});
    // Refresh falling due faster than it can be done
    apb(1'b1, `SRPM_OFS_REFRESH, 32'd2);
    repeat (60) @(posedge clk);
    apb(1'b1, `SRPM_OFS_IRQ_EN, 32'h1);
    @(posedge clk);
    chk("irq enabled", 32'h1, irq);
    rdc("mask", `SRPM_OFS_IRQ_MASK, 32'h1);
    apb(1'b1, `SRPM_OFS_IRQ_DIS, 32'h1);
    @(posedge clk);
    chk("irq disabled", 32'h0, irq);
    apb(1'b1, `SRPM_OFS_REFRESH, 32'd500);
    repeat (40) @(posedge clk);
    rdc("error pending", `SRPM_OFS_IRQ_STAT, 32'h1);
    rdc("error cleared", `SRPM_OFS_IRQ_STAT, 32'h0);
    $display("test refresh done");
    // Self-refresh: no controller refreshes, exit before the access
    apb(1'b1, `SRPM_OFS_LOWPWR, 32'h1);
    repeat (40) @(posedge clk);
    chk("self-refresh cke", 32'h0, cke);
    chk("self-refresh state", 32'h1, in_self);
    n = ref_cnt;
    repeat (1200) @(posedge clk);
    chk("refreshes in self-refresh", n, ref_cnt);
    apb(1'b1, `SRPM_OFS_REFRESH, 32'd4000);
    apb(1'b1, `SRPM_OFS_LOWPWR, 32'h1001);
    acc(1'b0, 1'b0, 13'h9, 11'h3);
    chk("exit latency", 32'h1, lat >= 11);
    chk("exit command", `SRPM_CMD_RD, cmd_at);
    repeat (60) @(posedge clk);
    chk("timeout not yet", 32'h1, cke);
    repeat (24) @(posedge clk);
    chk("timeout entered", 32'h0, cke);
    // Power-down keeps controller refreshes going
    apb(1'b1, `SRPM_OFS_REFRESH, 32'd500);
    apb(1'b1, `SRPM_OFS_LOWPWR, 32'h2);
    repeat (40) @(posedge clk);
    chk("power-down cke", 32'h0, cke);
    n = ref_cnt;
    repeat (1200) @(posedge clk);
    chk("refresh in power-down", 32'h1, ref_cnt > n);
    acc(1'b1, 1'b0, 13'h2, 11'h5);
    chk("power-down wake", `SRPM_CMD_WR, cmd_at);
    // Deep power-down by the low-power field; no access afterwards
    apb(1'b1, `SRPM_OFS_LOWPWR, 32'h3);
    repeat (40) @(posedge clk);
    chk("deep entered", 32'h1, in_deep);
    $display("test low power done");
    end_sim();
  end
endmodule
